/* File: src/acs_adc_seq_map.vh */
// register offsets, field positions, reset values and timing for the sequencer
`ifndef ACS_ADC_SEQ_MAP_VH
`define ACS_ADC_SEQ_MAP_VH

// result register offsets
`define ACS_OFS_EXT_IN0 8'h24
`define ACS_OFS_EXT_IN1 8'h25
`define ACS_OFS_TEMP 8'h26
`define ACS_OFS_DIAG 8'h27
`define ACS_OFS_OFFSET 8'h28
// control, configuration and status registers
`define ACS_OFS_FLAGS 8'h40
`define ACS_OFS_CFG 8'h41
`define ACS_OFS_INDEX 8'h42
`define ACS_OFS_TRIG 8'h43
`define ACS_OFS_BYPASS 8'h44

// configuration fields
`define ACS_CFG_SINGLE 0
`define ACS_CFG_SPAN 1
`define ACS_CFG_RATE_LO 2
`define ACS_CFG_RATE_HI 3
`define ACS_CFG_EXT1_EN 4
`define ACS_BYP_SKIP 0
`define ACS_FLAGS_BUSY 0
`define ACS_TRIG_BIT 0

// reset values
`define ACS_FIRST_RST 4'h0
`define ACS_LAST_RST 4'h8
`define ACS_CFG_RST 5'h10

// slot numbers
`define ACS_SLOT_OFFSET 4'h0
`define ACS_SLOT_EXT0 4'h1
`define ACS_SLOT_EXT1 4'h2
`define ACS_SLOT_TEMP 4'h3
`define ACS_SLOT_DIAG_LO 4'h4
`define ACS_SLOT_DIAG_HI 4'h8

// arithmetic
`define ACS_MID_CODE 12'h7ff
`define ACS_ZERO_CODE 12'h000

// converter clock: oscillator / 16, 20 converter clocks per conversion
`define ACS_CONV_DIV 16
`define ACS_CONV_CLKS 20
// rates in Hz, fixed internal rate and the four selectable external rates
`define ACS_OSC_HZ 1228800
`define ACS_RATE_FIXED_HZ 2560
`define ACS_RATE0_HZ 640
`define ACS_RATE1_HZ 1280
`define ACS_RATE2_HZ 2560
`define ACS_RATE3_HZ 3840

`endif

/* File: src/acs_rate_timer.v */
// slot timer: holds a slot for its conversion period in reference clocks
`timescale 1ns/10ps
module acs_rate_timer #(
    parameter CW = 16
) (
    input wire i_ref_clk,
    input wire i_rst_b,
    input wire i_start,
    input wire [CW-1:0] i_period,
    output reg o_done
);

reg [CW-1:0] cnt_r;
reg run_r;

// count down one slot period, pulse done on the last cycle
always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
        cnt_r <= {CW{1'b0}};
        run_r <= 1'b0;
        o_done <= 1'b0;
    end else begin
        o_done <= 1'b0;
        if (i_start) begin
            cnt_r <= i_period;
            run_r <= 1'b1;
        end else if (run_r) begin
            if (cnt_r <= {{(CW-1){1'b0}}, 1'b1}) begin
                run_r <= 1'b0;
                o_done <= 1'b1;
            end else begin
                cnt_r <= cnt_r - {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end
end

endmodule // acs_rate_timer

/* File: src/acs_adc_seq.v */
// channel sequencer, offset correction and result registers of the diag ADC
//
// Operation
// RULE1 - sixteen slots, first and last fields bound the converted range
// RULE2 - single-pass mode converts first through last once, then idles
// RULE3 - continuous mode wraps to first slot while still enabled
// RULE4 - equal first and last converts that one slot each pass
// RULE5 - reset values: first slot 0, last slot 8
// RULE6 - unconfigured external input 1 still timed, result forced zero
// RULE7 - first greater than last behaves as last equals first
// RULE8 - continuous: trigger 1 starts, 0 stops after current slot
// RULE9 - single-pass: trigger starts a pass and self-clears at end
// RULE10 - converter clock oscillator/16, conversion at least 20 clocks
// RULE11 - low io supply blocks software setting the wide-span bit
// RULE12 - software stops, waits for idle, then reconfigures
// RULE13 - results hold latest conversion, reads never disturb conversions
// RULE14 - slot 0 result is 7FFh minus code, two's complement
// RULE15 - offset subtracted by default, skip bit suppresses correction
// RULE16 - external slots rate 640, 1280, 2560 or 3840 Hz by field
// RULE17 - span bit: 0 twice reference, 1 reference, only above 2.7 V
// RULE18 - external input results go to their own registers
// RULE19 - slot 3 temperature at 2560 Hz into temperature register
// RULE20 - slots 4 to 8 diagnostics at 2560 Hz into diag register
// RULE21 - fixed slot order: offset, ext0, ext1, temperature
// RULE22 - busy flag high while converting, low when idle
// RULE23 - result written at slot end before advancing
`timescale 1ns/10ps
`include "acs_adc_seq_map.vh"
module acs_adc_seq #(
    parameter REF_HZ = 40000000,
    parameter SLOTS = 16,
    parameter SW = 4,
    parameter DW = 12,
    parameter CW = 16
) (
    input wire i_ref_clk,
    input wire i_rst_b,
    // register port
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [7:0] i_reg_addr,
    input wire [15:0] i_reg_wdata,
    output reg [15:0] o_reg_rdata,
    // supply level detector pin, high when io_supply above 2.7 V
    input wire i_io_supply_high,
    // conversion core
    input wire i_conv_valid,
    input wire [DW-1:0] i_conv_data,
    output reg o_conv_start,
    output reg [SW-1:0] o_mux_slot,
    output reg o_span_wide,
    output reg o_busy
);

////////////////////////////////////////////////////////////////////////////
// timing constants

// periods in reference clocks; the minimum is twenty converter clocks of
// sixteen oscillator periods rounded up, rates taken in kHz so the product
// stays inside 32 bits; integers first, then cut to the timer width
localparam integer MIN_INT =
    (`ACS_CONV_DIV * `ACS_CONV_CLKS * (REF_HZ / 1000) +
     (`ACS_OSC_HZ / 1000) - 1) / (`ACS_OSC_HZ / 1000);
localparam integer FIX_INT = REF_HZ / `ACS_RATE_FIXED_HZ;
localparam integer R0_INT = REF_HZ / `ACS_RATE0_HZ;
localparam integer R1_INT = REF_HZ / `ACS_RATE1_HZ;
localparam integer R2_INT = REF_HZ / `ACS_RATE2_HZ;
localparam integer R3_INT = REF_HZ / `ACS_RATE3_HZ;
localparam [CW-1:0] MIN_CYC = MIN_INT[CW-1:0]; // see RULE10
localparam [CW-1:0] FIX_CYC = FIX_INT[CW-1:0];
localparam [CW-1:0] R0_CYC = R0_INT[CW-1:0];
localparam [CW-1:0] R1_CYC = R1_INT[CW-1:0];
localparam [CW-1:0] R2_CYC = R2_INT[CW-1:0];
localparam [CW-1:0] R3_CYC = R3_INT[CW-1:0];

localparam [1:0] ST_IDLE = 2'd0;
localparam [1:0] ST_CONV = 2'd1;
localparam [1:0] ST_WAIT = 2'd2;

////////////////////////////////////////////////////////////////////////////
// supply pin synchroniser

reg sup_meta_r;
reg sup_sync_r;

// two flops before any logic sees the pin
always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
        sup_meta_r <= 1'b0;
        sup_sync_r <= 1'b0;
    end else begin
        sup_meta_r <= i_io_supply_high;
        sup_sync_r <= sup_meta_r;
    end
end

////////////////////////////////////////////////////////////////////////////
// configuration registers

reg [SW-1:0] first_r;
reg [SW-1:0] last_r;
reg single_r;
reg span_r;
reg [1:0] rate_r;
reg ext1_en_r;
reg skip_r;
reg trig_r;
reg [1:0] state_r;
reg [SW-1:0] slot_r;
reg stop_req_r;
reg pass_end_r;
reg [DW-1:0] ofs_r;
reg [15:0] ext0_res_r;
reg [15:0] ext1_res_r;
reg [15:0] temp_res_r;
reg [15:0] diag_res_r;
reg [15:0] ofs_res_r;

wire wr_cfg = i_reg_wr && (i_reg_addr == `ACS_OFS_CFG);
wire wr_idx = i_reg_wr && (i_reg_addr == `ACS_OFS_INDEX);
wire wr_trig = i_reg_wr && (i_reg_addr == `ACS_OFS_TRIG);
wire wr_byp = i_reg_wr && (i_reg_addr == `ACS_OFS_BYPASS);
// a zero written between slots must keep the next slot from starting
wire stop_wr = wr_trig && !i_reg_wdata[`ACS_TRIG_BIT]; // see RULE8
wire slot_done;
wire seq_end;

// software writes; the wide span can only be set with a high io supply
always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
        first_r <= `ACS_FIRST_RST; // see RULE5
        last_r <= `ACS_LAST_RST; // see RULE5
        {ext1_en_r, rate_r, span_r, single_r} <= `ACS_CFG_RST;
        skip_r <= 1'b0; // see RULE15
    end else begin
        if (wr_cfg) begin
            single_r <= i_reg_wdata[`ACS_CFG_SINGLE];
            span_r <= i_reg_wdata[`ACS_CFG_SPAN] & sup_sync_r; // see RULE11
            rate_r <= i_reg_wdata[`ACS_CFG_RATE_HI:`ACS_CFG_RATE_LO];
            ext1_en_r <= i_reg_wdata[`ACS_CFG_EXT1_EN];
        end else if (!sup_sync_r) begin
            span_r <= 1'b0; // see RULE11
        end
        if (wr_idx) begin
            first_r <= i_reg_wdata[SW-1:0]; // see RULE1
            last_r <= i_reg_wdata[2*SW-1:SW];
        end
        if (wr_byp)
            skip_r <= i_reg_wdata[`ACS_BYP_SKIP];
    end
end

////////////////////////////////////////////////////////////////////////////
// sequencer

// stop point: first wins when it exceeds last
wire [SW-1:0] stop_slot = (first_r > last_r) ? first_r : last_r; // see RULE7
wire at_stop = (slot_r == stop_slot); // see RULE4
wire [SW-1:0] slot_nxt = pass_end_r ? first_r :
                         slot_r + {{(SW-1){1'b0}}, 1'b1}; // see RULE3
assign seq_end = slot_done && at_stop;

// dummy slot: external input 1 unconfigured, nothing comes back
wire dummy = (slot_r == `ACS_SLOT_EXT1) && !ext1_en_r; // see RULE6

// slot that a timer start is about to open; the period, the mux and the
// core start must follow it, not the slot that has just ended
wire [SW-1:0] go_slot = (state_r == ST_IDLE) ? first_r :
                        (state_r == ST_WAIT) ? slot_nxt : slot_r;
wire go_dummy = (go_slot == `ACS_SLOT_EXT1) && !ext1_en_r; // see RULE6

// period per slot; external slots follow the rate field
reg [CW-1:0] period;
always @* begin
    period = FIX_CYC; // see RULE19
    if (go_slot == `ACS_SLOT_EXT0 || go_slot == `ACS_SLOT_EXT1) begin
        case (rate_r) // see RULE16
            2'd0: period = R0_CYC;
            2'd1: period = R1_CYC;
            2'd2: period = R2_CYC;
            default: period = R3_CYC;
        endcase
    end
    // the fastest rate can fall under the minimum; the clamp then wins
    if (period < MIN_CYC)
        period = MIN_CYC; // see RULE10
end

wire tmr_start = (state_r == ST_IDLE && trig_r) ||
                 (state_r == ST_WAIT && !stop_req_r && !stop_wr &&
                  !(single_r && pass_end_r) && trig_r);
reg got_r;
wire tmr_done;
// slot ends when its period expires; missing data enters the correction as a zero code
assign slot_done = (state_r == ST_CONV) && tmr_done;

acs_rate_timer #(.CW(CW)) u_tmr (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_start(tmr_start),
    .i_period(period),
    .o_done(tmr_done)
);

// state machine and trigger bit: a start opens the timer and the core,
// conv waits out the period, wait spends one cycle choosing the next slot,
// a wrap to the first slot, or idle
always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
        state_r <= ST_IDLE;
        slot_r <= `ACS_FIRST_RST;
        trig_r <= 1'b0;
        stop_req_r <= 1'b0;
    end else begin
        if (wr_trig) begin
            trig_r <= i_reg_wdata[`ACS_TRIG_BIT];
            if (!i_reg_wdata[`ACS_TRIG_BIT] && state_r != ST_IDLE)
                stop_req_r <= 1'b1; // see RULE8
        end
        case (state_r)
            ST_IDLE: begin
                stop_req_r <= 1'b0;
                slot_r <= first_r;
                if (trig_r)
                    state_r <= ST_CONV; // see RULE8
            end
            ST_CONV: begin
                if (slot_done)
                    state_r <= ST_WAIT; // see RULE23
            end
            ST_WAIT: begin
                if (stop_req_r || stop_wr || !trig_r) begin
                    state_r <= ST_IDLE; // see RULE8
                end else if (single_r && pass_end_r) begin
                    state_r <= ST_IDLE; // see RULE2
                    if (!wr_trig)
                        trig_r <= 1'b0; // see RULE9
                end else begin
                    slot_r <= slot_nxt; // see RULE3
                    state_r <= ST_CONV;
                end
            end
            default: state_r <= ST_IDLE;
        endcase
    end
end

// end of pass frozen when a slot finishes, so an index write landing in
// the wait cycle cannot stretch or cut the pass already decided
always @(posedge i_ref_clk) begin
    if (!i_rst_b)
        pass_end_r <= 1'b0;
    else if (slot_done)
        pass_end_r <= seq_end; // see RULE2
end

////////////////////////////////////////////////////////////////////////////
// result capture

// latest core data held until the slot ends
reg [DW-1:0] data_r;
always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
        data_r <= `ACS_ZERO_CODE;
        got_r <= 1'b0;
    end else if (tmr_start) begin
        got_r <= 1'b0;
    end else if (i_conv_valid && state_r == ST_CONV) begin
        data_r <= i_conv_data;
        got_r <= 1'b1;
    end
end

// twelve-bit arithmetic wraps on purpose: the offset is a small signed
// value, and corrected codes just under it roll over
wire [DW-1:0] raw = (dummy || !got_r) ? `ACS_ZERO_CODE : data_r;
wire [DW-1:0] ofs_val = `ACS_MID_CODE - raw; // see RULE14
wire [DW-1:0] corr = skip_r ? raw : raw - ofs_r; // see RULE15
wire [DW-1:0] res = dummy ? `ACS_ZERO_CODE : corr; // see RULE6

// each result of slots 0 to 8 lands in its register at slot end; reads are side effect free
always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
        ofs_r <= `ACS_ZERO_CODE;
        ext0_res_r <= 16'h0000;
        ext1_res_r <= 16'h0000;
        temp_res_r <= 16'h0000;
        diag_res_r <= 16'h0000;
        ofs_res_r <= 16'h0000;
    end else if (slot_done) begin // see RULE23
        if (slot_r == `ACS_SLOT_OFFSET) begin // see RULE21
            ofs_r <= ofs_val;
            ofs_res_r <= {{(16-DW){ofs_val[DW-1]}}, ofs_val}; // see RULE14
        end else if (slot_r == `ACS_SLOT_EXT0) begin
            ext0_res_r <= {{(16-DW){1'b0}}, res}; // see RULE18
        end else if (slot_r == `ACS_SLOT_EXT1) begin
            ext1_res_r <= {{(16-DW){1'b0}}, res}; // see RULE18
        end else if (slot_r == `ACS_SLOT_TEMP) begin
            temp_res_r <= {{(16-DW){1'b0}}, res}; // see RULE19
        end else if (slot_r <= `ACS_SLOT_DIAG_HI) begin
            diag_res_r <= {{(16-DW){1'b0}}, res}; // see RULE20
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// outputs

// read mux is registered so a read never touches the sequencer
always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
        o_reg_rdata <= 16'h0000;
        o_conv_start <= 1'b0;
        o_mux_slot <= `ACS_FIRST_RST;
        o_span_wide <= 1'b0;
        o_busy <= 1'b0;
    end else begin
        o_conv_start <= tmr_start && !go_dummy; // see RULE6
        // the mux moves with the start pulse so the core sees the new slot
        o_mux_slot <= tmr_start ? go_slot : slot_r; // see RULE21
        // span wide only when bit is 0 and supply is high
        o_span_wide <= !span_r && sup_sync_r; // see RULE17
        o_busy <= (state_r != ST_IDLE) || trig_r; // see RULE22
        if (i_reg_rd) begin
            case (i_reg_addr) // see RULE13
                `ACS_OFS_EXT_IN0: o_reg_rdata <= ext0_res_r;
                `ACS_OFS_EXT_IN1: o_reg_rdata <= ext1_res_r;
                `ACS_OFS_TEMP: o_reg_rdata <= temp_res_r;
                `ACS_OFS_DIAG: o_reg_rdata <= diag_res_r;
                `ACS_OFS_OFFSET: o_reg_rdata <= ofs_res_r;
                `ACS_OFS_FLAGS:
                    o_reg_rdata <= {15'h0000, state_r != ST_IDLE};
                `ACS_OFS_CFG:
                    o_reg_rdata <= {11'h000, ext1_en_r, rate_r, span_r,
                                    single_r};
                `ACS_OFS_INDEX: o_reg_rdata <= {8'h00, last_r, first_r};
                `ACS_OFS_TRIG: o_reg_rdata <= {15'h0000, trig_r};
                `ACS_OFS_BYPASS: o_reg_rdata <= {15'h0000, skip_r};
                default: o_reg_rdata <= 16'h0000;
            endcase
        end
    end
end

endmodule // acs_adc_seq

/* File: tb/acs_adc_seq_sva.sv */
// port checker for the channel sequencer
`timescale 1ns/10ps
`include "acs_adc_seq_map.vh"
module acs_adc_seq_sva (
    input wire i_ref_clk,
    input wire i_rst_b,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [7:0] i_reg_addr,
    input wire [15:0] i_reg_wdata,
    input wire [15:0] o_reg_rdata,
    input wire i_io_supply_high,
    input wire o_conv_start,
    input wire [3:0] o_mux_slot,
    input wire o_span_wide,
    input wire o_busy
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    ////////////////////////////////////////////////////////////////////////
    // sequencer state and timing
    AST_START_BUSY: assert property (o_conv_start |-> o_busy)
        else $error("conversion start while idle");
    AST_IDLE_AFTER_RESET: assert property ($rose(i_rst_b) |-> !o_busy)
        else $error("busy right after reset");
    AST_TRIG_BUSY: assert property (i_reg_wr && i_reg_wdata[0] &&
        i_reg_addr == `ACS_OFS_TRIG |-> ##[1:3] o_busy)
        else $error("trigger did not raise busy");
    // a conversion lasts far longer than eight cycles
    AST_CONV_GAP: assert property (o_conv_start |=> !o_conv_start[*8])
        else $error("conversion starts too close");
    AST_SLOT_HELD: assert property (o_conv_start |=> $stable(o_mux_slot)[*8])
        else $error("slot changed inside a conversion");
    ////////////////////////////////////////////////////////////////////////
    // register port and span control
    AST_SPAN_LOW: assert property ((!i_io_supply_high)[*4] |-> !o_span_wide)
        else $error("wide span with low io supply");
    AST_RDATA_HOLDS: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
        else $error("read data moved without a read");
    AST_INDEX_READBACK: assert property ((i_reg_wr &&
        i_reg_addr == `ACS_OFS_INDEX ##1 !i_reg_wr ##1 i_reg_rd &&
        i_reg_addr == `ACS_OFS_INDEX) |=>
        o_reg_rdata[7:0] == $past(i_reg_wdata[7:0], 3))
        else $error("index readback differs");
endmodule // acs_adc_seq_sva
bind acs_adc_seq acs_adc_seq_sva i_sva (.i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_io_supply_high(i_io_supply_high),
    .o_conv_start(o_conv_start), .o_mux_slot(o_mux_slot),
    .o_span_wide(o_span_wide), .o_busy(o_busy));

/* File: tb/acs_adc_seq_tb.sv */
// self-checking bench for the channel sequencer
`timescale 1ns/10ps
`include "acs_adc_seq_map.vh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
    $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module acs_adc_seq_tb;
    reg i_ref_clk = 1'b0;
    reg i_rst_b = 1'b0;
    reg i_reg_wr = 1'b0;
    reg i_reg_rd = 1'b0;
    reg [7:0] i_reg_addr = 8'h00;
    reg [15:0] i_reg_wdata = 16'h0000;
    reg i_io_supply_high = 1'b1;
    reg i_conv_valid = 1'b0;
    reg [11:0] i_conv_data = 12'h000;
    wire [15:0] o_reg_rdata;
    wire o_conv_start;
    wire [3:0] o_mux_slot;
    wire o_span_wide;
    wire o_busy;
    integer n_errors = 0;
    integer n_tests = 0;
    integer n_starts = 0;
    integer i;
    integer k;
    reg [3:0] last_slot = 4'h0;
    // short periods: 400 kHz reference keeps each slot period between 105 and 625 cycles
    acs_adc_seq #(.REF_HZ(400000)) i_dut (.i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .i_io_supply_high(i_io_supply_high),
        .i_conv_valid(i_conv_valid), .i_conv_data(i_conv_data),
        .o_conv_start(o_conv_start), .o_mux_slot(o_mux_slot),
        .o_span_wide(o_span_wide), .o_busy(o_busy));
    always #12.5 i_ref_clk = ~i_ref_clk;
    ////////////////////////////////////////////////////////////////////////
    // core stand-in: slot 0 reads 7fdh (offset 2), others 100h plus slot
    always @(negedge i_ref_clk) begin
        i_conv_valid <= o_conv_start;
        if (o_conv_start) begin
            n_starts <= n_starts + 1;
            last_slot <= o_mux_slot;
            i_conv_data <= (o_mux_slot == 4'h0) ? 12'h7fd
                : 12'h100 + {8'h00, o_mux_slot};
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // register port tasks, all entered at a falling edge
    task wr(input [7:0] a, input [15:0] d);
        begin
            i_reg_addr = a;
            i_reg_wdata = d;
            i_reg_wr = 1'b1;
            @(negedge i_ref_clk);
            i_reg_wr = 1'b0;
            // one quiet edge so a following write never re-raises the strobe
            @(negedge i_ref_clk);
        end
    endtask
    task rchk(input [7:0] a, input [15:0] e);
        begin
            i_reg_addr = a;
            i_reg_rd = 1'b1;
            @(negedge i_ref_clk);
            i_reg_rd = 1'b0;
            @(negedge i_ref_clk);
            `CHK(o_reg_rdata, e)
        end
    endtask
    task tally_and_finish;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, n_errors);
            if (n_errors == 0 && n_tests > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    // bounded wait for idle before any reconfiguration
    task wait_idle;
        begin
            repeat (3) @(negedge i_ref_clk);
            for (i = 0; i < 4000 && o_busy !== 1'b0; i++)
                @(negedge i_ref_clk);
            if (o_busy !== 1'b0) begin
                n_errors++;
                $display("mismatch t=%0t busy %h exp %h", $time, o_busy, 1'b0);
                tally_and_finish;
            end
        end
    endtask
    task run(input [7:0] idx);
        begin
            wr(`ACS_OFS_INDEX, {8'h00, idx});
            k = n_starts;
            wr(`ACS_OFS_TRIG, 16'h0001);
            wait_idle;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task t_reset;
        begin
            rchk(`ACS_OFS_INDEX, 16'h0080);
            rchk(`ACS_OFS_CFG, 16'h0010);
            rchk(8'h30, 16'h0000);
            $display("reset values done");
        end
    endtask
    task t_single;
        begin
            wr(`ACS_OFS_CFG, 16'h001d);
            run(8'h00);
            `CHK(n_starts - k, 1)
            rchk(`ACS_OFS_OFFSET, 16'h0002);
            rchk(`ACS_OFS_TRIG, 16'h0000);
            wr(`ACS_OFS_INDEX, 16'h0043);
            rchk(`ACS_OFS_INDEX, 16'h0043);
            run(8'h43);
            `CHK(n_starts - k, 2)
            `CHK(last_slot, 4'h4)
            rchk(`ACS_OFS_TEMP, 16'h0101);
            rchk(`ACS_OFS_DIAG, 16'h0102);
            wr(`ACS_OFS_BYPASS, 16'h0001);
            run(8'h55);
            rchk(`ACS_OFS_DIAG, 16'h0105);
            wr(`ACS_OFS_BYPASS, 16'h0000);
            run(8'h35);
            `CHK(n_starts - k, 1)
            `CHK(last_slot, 4'h5)
            rchk(`ACS_OFS_DIAG, 16'h0103);
            $display("single pass done");
        end
    endtask
    task t_ext;
        begin
            run(8'h22);
            rchk(`ACS_OFS_EXT_IN1, 16'h0100);
            wr(`ACS_OFS_CFG, 16'h000d);
            run(8'h21);
            `CHK(n_starts - k, 1)
            rchk(`ACS_OFS_EXT_IN0, 16'h00ff);
            rchk(`ACS_OFS_EXT_IN1, 16'h0000);
            $display("external inputs done");
        end
    endtask
    task t_cont;
        begin
            // rate 0 on ext0: three starts span two full 640 Hz periods
            wr(`ACS_OFS_CFG, 16'h0010);
            wr(`ACS_OFS_INDEX, 16'h0011);
            k = n_starts;
            wr(`ACS_OFS_TRIG, 16'h0001);
            for (i = 0; i < 4000 && n_starts - k < 3; i++)
                @(negedge i_ref_clk);
            `CHK(n_starts - k >= 3, 1'b1)
            if (n_starts - k < 3)
                tally_and_finish;
            // 2 x 625 cycles at 400 kHz, less a little start-up slack
            `CHK(i >= 1200, 1'b1)
            wr(`ACS_OFS_TRIG, 16'h0000);
            wait_idle;
            k = n_starts;
            repeat (300) @(negedge i_ref_clk);
            `CHK(n_starts, k)
            $display("continuous done");
        end
    endtask
    task t_span;
        begin
            i_io_supply_high = 1'b0;
            repeat (4) @(negedge i_ref_clk);
            wr(`ACS_OFS_CFG, 16'h0003);
            rchk(`ACS_OFS_CFG, 16'h0001);
            `CHK(o_span_wide, 1'b0)
            i_io_supply_high = 1'b1;
            repeat (4) @(negedge i_ref_clk);
            wr(`ACS_OFS_CFG, 16'h0000);
            repeat (2) @(negedge i_ref_clk);
            `CHK(o_span_wide, 1'b1)
            wr(`ACS_OFS_CFG, 16'h0002);
            repeat (2) @(negedge i_ref_clk);
            `CHK(o_span_wide, 1'b0)
            $display("span done");
        end
    endtask
    // main sequence
    initial begin
        repeat (8) @(negedge i_ref_clk);
        i_rst_b = 1'b1;
        t_reset;
        t_single;
        t_ext;
        t_cont;
        t_span;
        tally_and_finish;
    end
endmodule // acs_adc_seq_tb
